// ### plsc_bank.v
// limit, response and status command bank with a word and byte command port
// Overview of operation
// - input turn-on threshold word, exp -3, 33-36
// - input turn-off threshold word, exp -3, 31-34
// - output overvoltage fault word, exp -12, 15
// - output overvoltage warn word, default 14
// - overvoltage response reads fixed 0xB8
// - overcurrent fault word, exp -4, 33-55
// - overcurrent response reads fixed 0xF8
// - current warn word, exp -4, 47
// - overtemperature fault word, exp -2, 125
// - overtemperature response reads fixed 0xB8
// - temperature warn word, 100, 25-135
// - input overvoltage fault word, 48-100
// - input overvoltage response reads fixed 0xF8
// - power good sets at assert level
// - power good clears at negate level
// - wait turn-on delay before ramp
// - ramp output over rise time
// - summary word reports all conditions
// - output voltage condition byte, read/write
// - output current condition byte, read/write
// - linear11 words: 11-bit mantissa, 5-bit exponent
// - output voltage words: 16-bit unsigned, exp -12
// - fixed exponent per command
`timescale 1ns/10ps
`include "plsc_consts.vh"
module plsc_bank (
	core_clk,
	reset_n,
	cmd_wr,
	cmd_rd,
	cmd_code,
	cmd_wdata,
	cmd_word,
	vout_meas,
	iout_meas,
	temp_meas,
	vin_meas,
	start_req,
	tick_in,
	cmd_rdata,
	cmd_ack,
	cmd_rej,
	pgood,
	ramp_active,
	ramp_target_frac
);
	input wire core_clk;
	input wire reset_n;
	input wire cmd_wr;
	input wire cmd_rd;
	input wire [7:0] cmd_code;
	input wire [15:0] cmd_wdata;
	input wire cmd_word;
	input wire [15:0] vout_meas;
	input wire [10:0] iout_meas;
	input wire [10:0] temp_meas;
	input wire [10:0] vin_meas;
	input wire start_req;
	input wire tick_in;
	output reg [15:0] cmd_rdata;
	output reg cmd_ack;
	output reg cmd_rej;
	output reg pgood;
	output reg ramp_active;
	output reg [9:0] ramp_target_frac;

	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_RAMP = 2'h2;
	localparam ST_ON = 2'h3;
	localparam [15:0] HALF_MS_CYC = `PLSC_HALF_MS_CYC;

	reg [15:0] vin_on_r, vin_off_r, vout_ovf_r, vout_ovw_r, iout_ocf_r, iout_ocw_r;
	reg [15:0] otf_r, otw_r, vin_ovf_r, pg_on_r, pg_off_r, ton_wait_r, ton_ramp_r;
	reg [7:0] vout_cond_r, iout_cond_r;
	reg temp_ovf_r, temp_ovw_r, vin_ov_r, vin_uv_r;
	reg [1:0] state_r;
	reg [15:0] half_ms_cnt_r;
	reg [10:0] time_cnt_r;
	reg start_d_r, tick_d_r;
	wire start_s, tick_s;

	wire ok_vin_on, ok_vin_off, ok_iout, ok_temp, ok_vin_ovf, ok_wait, ok_ramp;
	// external pins cross into core_clk through two flops
	plsc_sync u_sync_start (.core_clk(core_clk), .reset_n(reset_n), .din(start_req), .dout(start_s));
	plsc_sync u_sync_tick (.core_clk(core_clk), .reset_n(reset_n), .din(tick_in), .dout(tick_s));

	plsc_ltck #(.EXP(`PLSC_EXP_M3), .MIN(`PLSC_MIN_VIN_ON), .MAX(`PLSC_MAX_VIN_ON))
		u_ck_von (.word(cmd_wdata), .ok(ok_vin_on));
	plsc_ltck #(.EXP(`PLSC_EXP_M3), .MIN(`PLSC_MIN_VIN_OFF), .MAX(`PLSC_MAX_VIN_OFF))
		u_ck_voff (.word(cmd_wdata), .ok(ok_vin_off));
	plsc_ltck #(.EXP(`PLSC_EXP_M4), .MIN(`PLSC_MIN_IOUT), .MAX(`PLSC_MAX_IOUT))
		u_ck_iout (.word(cmd_wdata), .ok(ok_iout));
	plsc_ltck #(.EXP(`PLSC_EXP_M2), .MIN(`PLSC_MIN_TEMP), .MAX(`PLSC_MAX_TEMP))
		u_ck_temp (.word(cmd_wdata), .ok(ok_temp));
	plsc_ltck #(.EXP(`PLSC_EXP_M3), .MIN(`PLSC_MIN_VIN_OVF), .MAX(`PLSC_MAX_VIN_OVF))
		u_ck_vinov (.word(cmd_wdata), .ok(ok_vin_ovf));
	plsc_ltck #(.EXP(`PLSC_EXP_M1), .MIN(`PLSC_MIN_TON_WAIT), .MAX(`PLSC_MAX_TON_WAIT))
		u_ck_wait (.word(cmd_wdata), .ok(ok_wait));
	plsc_ltck #(.EXP(`PLSC_EXP_M1), .MIN(`PLSC_MIN_TON_RAMP), .MAX(`PLSC_MAX_TON_RAMP))
		u_ck_ramp (.word(cmd_wdata), .ok(ok_ramp));

	// output voltage words are plain unsigned mantissas
	wire ok_vout_ov = (cmd_wdata >= `PLSC_MIN_VOUT_OV) && (cmd_wdata <= `PLSC_MAX_VOUT_OV);
	wire ok_vout_pg = (cmd_wdata >= `PLSC_MIN_VOUT_PG) && (cmd_wdata <= `PLSC_MAX_VOUT_PG);

	// live conditions; measurements share the exponent of their limit word
	wire ovf_now = vout_meas >= vout_ovf_r;
	wire ovw_now = vout_meas >= vout_ovw_r;
	wire ocf_now = iout_meas >= iout_ocf_r[10:0];
	wire ocw_now = iout_meas >= iout_ocw_r[10:0];
	wire otf_now = temp_meas >= otf_r[10:0];
	wire otw_now = temp_meas >= otw_r[10:0];
	wire vinov_now = vin_meas >= vin_ovf_r[10:0];
	wire vinuv_now = vin_meas <= vin_off_r[10:0];

	reg is_word_cmd, is_byte_cmd, legal_wr;
	always @* begin
		is_word_cmd = 1'b0;
		is_byte_cmd = 1'b0;
		legal_wr = 1'b0;
		case (cmd_code)
			`PLSC_CMD_VIN_ON: begin
				is_word_cmd = 1'b1;
				legal_wr = ok_vin_on;
			end
			`PLSC_CMD_VIN_OFF: begin
				is_word_cmd = 1'b1;
				legal_wr = ok_vin_off;
			end
			`PLSC_CMD_VOUT_OVF, `PLSC_CMD_VOUT_OVW: begin
				is_word_cmd = 1'b1;
				legal_wr = ok_vout_ov;
			end
			`PLSC_CMD_IOUT_OCF, `PLSC_CMD_IOUT_OCW: begin
				is_word_cmd = 1'b1;
				legal_wr = ok_iout;
			end
			`PLSC_CMD_OTF, `PLSC_CMD_OTW: begin
				is_word_cmd = 1'b1;
				legal_wr = ok_temp;
			end
			`PLSC_CMD_VIN_OVF: begin
				is_word_cmd = 1'b1;
				legal_wr = ok_vin_ovf;
			end
			`PLSC_CMD_PG_ON, `PLSC_CMD_PG_OFF: begin
				is_word_cmd = 1'b1;
				legal_wr = ok_vout_pg;
			end
			`PLSC_CMD_TON_WAIT: begin
				is_word_cmd = 1'b1;
				legal_wr = ok_wait;
			end
			`PLSC_CMD_TON_RAMP: begin
				is_word_cmd = 1'b1;
				legal_wr = ok_ramp;
			end
			`PLSC_CMD_SUMMARY: is_word_cmd = 1'b1;
			`PLSC_CMD_VOUT_COND, `PLSC_CMD_IOUT_COND: begin
				is_byte_cmd = 1'b1;
				legal_wr = 1'b1;
			end
			`PLSC_CMD_VOUT_OVF_ACT, `PLSC_CMD_IOUT_OCF_ACT, `PLSC_CMD_OTF_ACT, `PLSC_CMD_VIN_OVF_ACT:
				is_byte_cmd = 1'b1;
			default: begin
				is_word_cmd = 1'b0;
			end
		endcase
	end

	// writes need the right transfer width; limits outside range keep the old value
	wire wr_ok = cmd_wr && legal_wr && ((is_word_cmd && cmd_word) || (is_byte_cmd && !cmd_word));
	wire wr_lim = wr_ok && is_word_cmd;
	wire clr_vc = wr_ok && (cmd_code == `PLSC_CMD_VOUT_COND);
	wire clr_ic = wr_ok && (cmd_code == `PLSC_CMD_IOUT_COND);

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			vin_on_r <= `PLSC_RST_VIN_ON;
			vin_off_r <= `PLSC_RST_VIN_OFF;
			vout_ovf_r <= `PLSC_RST_VOUT_OVF;
			vout_ovw_r <= `PLSC_RST_VOUT_OVW;
			iout_ocf_r <= `PLSC_RST_IOUT_OCF;
			iout_ocw_r <= `PLSC_RST_IOUT_OCW;
			otf_r <= `PLSC_RST_OTF;
			otw_r <= `PLSC_RST_OTW;
			vin_ovf_r <= `PLSC_RST_VIN_OVF;
			pg_on_r <= `PLSC_RST_PG_ON;
			pg_off_r <= `PLSC_RST_PG_OFF;
			ton_wait_r <= `PLSC_RST_TON_WAIT;
			ton_ramp_r <= `PLSC_RST_TON_RAMP;
		end else if (wr_lim) begin
			case (cmd_code)
				`PLSC_CMD_VIN_ON: vin_on_r <= cmd_wdata;
				`PLSC_CMD_VIN_OFF: vin_off_r <= cmd_wdata;
				`PLSC_CMD_VOUT_OVF: vout_ovf_r <= cmd_wdata;
				`PLSC_CMD_VOUT_OVW: vout_ovw_r <= cmd_wdata;
				`PLSC_CMD_IOUT_OCF: iout_ocf_r <= cmd_wdata;
				`PLSC_CMD_IOUT_OCW: iout_ocw_r <= cmd_wdata;
				`PLSC_CMD_OTF: otf_r <= cmd_wdata;
				`PLSC_CMD_OTW: otw_r <= cmd_wdata;
				`PLSC_CMD_VIN_OVF: vin_ovf_r <= cmd_wdata;
				`PLSC_CMD_PG_ON: pg_on_r <= cmd_wdata;
				`PLSC_CMD_PG_OFF: pg_off_r <= cmd_wdata;
				`PLSC_CMD_TON_WAIT: ton_wait_r <= cmd_wdata;
				`PLSC_CMD_TON_RAMP: ton_ramp_r <= cmd_wdata;
				default: vin_on_r <= vin_on_r;
			endcase
		end
	end

	// sticky conditions: a write of 1 clears a vout or iout condition bit, a live condition wins over the clear; temperature and input bits clear only on reset
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			vout_cond_r <= 8'h00;
			iout_cond_r <= 8'h00;
			temp_ovf_r <= 1'b0;
			temp_ovw_r <= 1'b0;
			vin_ov_r <= 1'b0;
			vin_uv_r <= 1'b0;
		end else begin
			vout_cond_r <= (vout_cond_r & ~(clr_vc ? cmd_wdata[7:0] : 8'h00))
				| ({ovf_now, ovw_now, 6'h00});
			iout_cond_r <= (iout_cond_r & ~(clr_ic ? cmd_wdata[7:0] : 8'h00))
				| ({ocf_now, 1'b0, ocw_now, 5'h00});
			temp_ovf_r <= temp_ovf_r | otf_now;
			temp_ovw_r <= temp_ovw_r | otw_now;
			vin_ov_r <= vin_ov_r | vinov_now;
			vin_uv_r <= vin_uv_r | vinuv_now;
		end
	end

	// power good with hysteresis between assert and negate levels
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pgood <= 1'b0;
		end else if (state_r != ST_ON && state_r != ST_RAMP) begin
			pgood <= 1'b0;
		end else if (!pgood && vout_meas >= pg_on_r) begin
			pgood <= 1'b1;
		end else if (pgood && vout_meas <= pg_off_r) begin
			pgood <= 1'b0;
		end
	end

	// start sequence: wait, then ramp; times count in half-ms units of the core clock
	wire half_ms = (half_ms_cnt_r == HALF_MS_CYC - 16'h0001);
	wire tick_rise = tick_s & ~tick_d_r;
	// start only when input is at or above the turn-on level and no input overvoltage holds
	wire start_ok = start_s && !start_d_r && (vin_meas >= vin_on_r[10:0]) && !vinov_now;
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
			half_ms_cnt_r <= 16'h0000;
			time_cnt_r <= 11'h000;
			start_d_r <= 1'b0;
			tick_d_r <= 1'b0;
			ramp_active <= 1'b0;
			ramp_target_frac <= 10'h000;
		end else begin
			start_d_r <= start_s;
			tick_d_r <= tick_s;
			half_ms_cnt_r <= (half_ms || state_r == ST_IDLE || state_r == ST_ON) ? 16'h0000
				: half_ms_cnt_r + 16'h0001;
			case (state_r)
				ST_IDLE: begin
					ramp_active <= 1'b0;
					ramp_target_frac <= 10'h000;
					time_cnt_r <= 11'h000;
					if (start_ok)
						state_r <= ST_WAIT;
				end
				ST_WAIT: begin
					if (half_ms)
						time_cnt_r <= time_cnt_r + 11'h001;
					if (time_cnt_r >= ton_wait_r[10:0]) begin
						state_r <= ST_RAMP;
						time_cnt_r <= 11'h000;
						ramp_active <= 1'b1;
					end
				end
				ST_RAMP: begin
					if (half_ms)
						time_cnt_r <= time_cnt_r + 11'h001;
					ramp_target_frac <= time_cnt_r[9:0];
					if (time_cnt_r >= ton_ramp_r[10:0]) begin
						state_r <= ST_ON;
						ramp_active <= 1'b0;
						ramp_target_frac <= 10'h3FF;
					end
				end
				ST_ON: begin
					// a fault or input undervoltage drops the output back to idle
					if (ovf_now || ocf_now || otf_now || vinov_now || vinuv_now)
						state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
			if (tick_rise && state_r == ST_IDLE)
				time_cnt_r <= 11'h000;
		end
	end

	// summary word collects every class of condition
	reg [15:0] summary;
	always @* begin
		summary = 16'h0000;
		summary[`PLSC_SW_VOUT] = |vout_cond_r;
		summary[`PLSC_SW_IOUT] = |iout_cond_r;
		summary[`PLSC_SW_INPUT] = vin_ov_r | vin_uv_r;
		summary[`PLSC_SW_PGN] = !pgood;
		summary[`PLSC_SW_OFF] = (state_r == ST_IDLE);
		summary[`PLSC_SW_VOV] = vout_cond_r[`PLSC_VC_OVF];
		summary[`PLSC_SW_IOC] = iout_cond_r[`PLSC_IC_OCF];
		summary[`PLSC_SW_VUV] = vin_uv_r;
		summary[`PLSC_SW_TEMP] = temp_ovf_r | temp_ovw_r;
	end

	reg [15:0] rd_mux;
	always @* begin
		rd_mux = 16'h0000;
		case (cmd_code)
			`PLSC_CMD_VIN_ON: rd_mux = vin_on_r;
			`PLSC_CMD_VIN_OFF: rd_mux = vin_off_r;
			`PLSC_CMD_VOUT_OVF: rd_mux = vout_ovf_r;
			`PLSC_CMD_VOUT_OVF_ACT: rd_mux = {8'h00, `PLSC_RST_OVF_ACT};
			`PLSC_CMD_VOUT_OVW: rd_mux = vout_ovw_r;
			`PLSC_CMD_IOUT_OCF: rd_mux = iout_ocf_r;
			`PLSC_CMD_IOUT_OCF_ACT: rd_mux = {8'h00, `PLSC_RST_OCF_ACT};
			`PLSC_CMD_IOUT_OCW: rd_mux = iout_ocw_r;
			`PLSC_CMD_OTF: rd_mux = otf_r;
			`PLSC_CMD_OTF_ACT: rd_mux = {8'h00, `PLSC_RST_OTF_ACT};
			`PLSC_CMD_OTW: rd_mux = otw_r;
			`PLSC_CMD_VIN_OVF: rd_mux = vin_ovf_r;
			`PLSC_CMD_VIN_OVF_ACT: rd_mux = {8'h00, `PLSC_RST_VINF_ACT};
			`PLSC_CMD_PG_ON: rd_mux = pg_on_r;
			`PLSC_CMD_PG_OFF: rd_mux = pg_off_r;
			`PLSC_CMD_TON_WAIT: rd_mux = ton_wait_r;
			`PLSC_CMD_TON_RAMP: rd_mux = ton_ramp_r;
			`PLSC_CMD_SUMMARY: rd_mux = summary;
			`PLSC_CMD_VOUT_COND: rd_mux = {8'h00, vout_cond_r};
			`PLSC_CMD_IOUT_COND: rd_mux = {8'h00, iout_cond_r};
			default: rd_mux = 16'h0000;
		endcase
	end

	// ack one cycle after any accepted access; rej flags unknown codes and refused writes
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_rdata <= 16'h0000;
			cmd_ack <= 1'b0;
			cmd_rej <= 1'b0;
		end else begin
			cmd_ack <= (cmd_rd && (is_word_cmd || is_byte_cmd)) || wr_ok;
			cmd_rej <= (cmd_rd && !(is_word_cmd || is_byte_cmd)) || (cmd_wr && !wr_ok);
			if (cmd_rd)
				cmd_rdata <= rd_mux;
		end
	end
endmodule // plsc_bank

// ### plsc_bank_properties.sv
// bound checks on the command bank ports
`timescale 1ns/10ps
module plsc_bank_properties (
	input wire core_clk,
	input wire reset_n,
	input wire cmd_wr,
	input wire cmd_rd,
	input wire [7:0] cmd_code,
	input wire [15:0] cmd_wdata,
	input wire cmd_word,
	input wire [15:0] cmd_rdata,
	input wire cmd_ack,
	input wire cmd_rej,
	input wire pgood
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	wire [7:0] c = cmd_code;
	wire [10:0] m = cmd_wdata[10:0];
	answer_once_a: assert property ((cmd_wr || cmd_rd) |=> cmd_ack ^ cmd_rej)
		else $error("request not answered once");
	no_stray_a: assert property ((cmd_ack || cmd_rej) |-> $past(cmd_wr || cmd_rd))
		else $error("answer without request");
	ro_write_a: assert property (cmd_wr && (c == 8'h41 || c == 8'h47 || c == 8'h50 || c == 8'h56) |=> cmd_rej)
		else $error("read-only write taken");
	ov_action_a: assert property (cmd_rd && c == 8'h41 |=> cmd_ack && cmd_rdata[7:0] == 8'hB8)
		else $error("bad overvoltage action");
	oc_action_a: assert property (cmd_rd && c == 8'h47 |=> cmd_ack && cmd_rdata[7:0] == 8'hF8)
		else $error("bad overcurrent action");
	ot_action_a: assert property (cmd_rd && c == 8'h50 |=> cmd_ack && cmd_rdata[7:0] == 8'hB8)
		else $error("bad overtemperature action");
	vin_action_a: assert property (cmd_rd && c == 8'h56 |=> cmd_ack && cmd_rdata[7:0] == 8'hF8)
		else $error("bad input overvoltage action");
	vin_on_range_a: assert property (cmd_wr && c == 8'h35 && (m < 11'h108 || m > 11'h120) |=> cmd_rej)
		else $error("turn-on threshold out of range taken");
	exp_fixed_a: assert property (cmd_wr && c == 8'h60 && (!cmd_word || cmd_wdata[15:11] != 5'h1F) |=> cmd_rej)
		else $error("wrong exponent or width taken");
	cond_byte_a: assert property (cmd_wr && !cmd_word && (c == 8'h7A || c == 8'h7B) |=> cmd_ack)
		else $error("condition byte write refused");
	pg_summary_a: assert property (cmd_rd && c == 8'h79 |=> cmd_rdata[11] == !$past(pgood))
		else $error("summary power good bit wrong");
endmodule // plsc_bank_properties

// ### plsc_bank_tb.sv
// self-checking bench for the limit and status command bank
`timescale 1ns/10ps
module plsc_bank_tb;
	reg core_clk;
	reg reset_n;
	wire cmd_wr, cmd_rd, cmd_word, cmd_ack, cmd_rej, pgood, ramp_active;
	wire [7:0] cmd_code;
	wire [15:0] cmd_wdata, cmd_rdata;
	wire [9:0] ramp_target_frac;
	reg [15:0] vout_meas;
	reg [10:0] iout_meas, temp_meas, vin_meas;
	reg start_req, tick_in;
	int errors, comparisons, gap;
	logic [7:0] dcode [13] = '{8'h35, 8'h36, 8'h40, 8'h42, 8'h46, 8'h4A, 8'h4F, 8'h51, 8'h55, 8'h5E, 8'h5F, 8'h60, 8'h61};
	logic [15:0] dval [13] = '{16'hE918, 16'hE908, 16'hF000, 16'hE000, 16'hE350, 16'hE2F0, 16'hF1F4,
		16'hF190, 16'hEB20, 16'hB000, 16'h9000, 16'hF828, 16'hF83C};
	logic [7:0] rcode [4] = '{8'h41, 8'h47, 8'h50, 8'h56};
	logic [7:0] rval [4] = '{8'hB8, 8'hF8, 8'hB8, 8'hF8};
	plsc_bank plsc_bank_i (.core_clk(core_clk), .reset_n(reset_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_word(cmd_word), .vout_meas(vout_meas),
		.iout_meas(iout_meas), .temp_meas(temp_meas), .vin_meas(vin_meas), .start_req(start_req),
		.tick_in(tick_in), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_rej(cmd_rej), .pgood(pgood),
		.ramp_active(ramp_active), .ramp_target_frac(ramp_target_frac));
	plsc_host plsc_host_i (.core_clk(core_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .cmd_word(cmd_word), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_rej(cmd_rej));
	task final_report;
		begin
			if (errors == 0 && comparisons > 0) begin
				$display("All checks passed");
			end else begin
				$display("Checks failed");
			end
			$finish;
		end
	endtask
	task chk(input string what, input [15:0] e, input [15:0] g);
		begin
			comparisons++;
			if (g !== e) begin
				errors++;
				$display("wrong value %s expected %h seen %h", what, e, g);
			end
		end
	endtask
	task acc(input bit wr, input [7:0] code, input [15:0] d, input bit word, input bit ok, output [15:0] r);
		bit ack, rej, hung;
		begin
			plsc_host_i.xfer(wr, code, d, word, gap, ack, rej, r, hung);
			if (hung) begin
				errors++;
				final_report;
			end
			chk("answer", {14'h0, ok, !ok}, {14'h0, ack, rej});
		end
	endtask
	task lim(input [7:0] code, input [15:0] d, input bit ok, input [15:0] e);
		reg [15:0] r;
		begin
			acc(1, code, d, 1, ok, r);
			acc(0, code, 16'h0000, 1, 1, r);
			chk("limit word", e, r);
		end
	endtask
	task rdm(input [7:0] code, input [15:0] mask, input [15:0] e);
		reg [15:0] r;
		begin
			acc(0, code, 16'h0000, code == 8'h79, 1, r);
			chk("condition bits", e, r & mask);
		end
	endtask
	task t_defaults;
		reg [15:0] r;
		begin
			for (int i = 0; i < 13; i++) begin
				acc(0, dcode[i], 16'h0000, 1, 1, r);
				chk("default", dval[i], r);
			end
			for (int i = 0; i < 4; i++) begin
				acc(1, rcode[i], 16'h0055, 0, 0, r);
				acc(0, rcode[i], 16'h0000, 0, 1, r);
				chk("action", {8'h00, rval[i]}, {8'h00, r[7:0]});
			end
			acc(1, 8'h79, 16'h0000, 1, 0, r);
			acc(1, 8'h35, 16'hE910, 0, 0, r);
		end
	endtask
	task t_limits;
		begin
			lim(8'h36, 16'hE8F8, 1, 16'hE8F8);
			lim(8'h36, 16'hE911, 0, 16'hE8F8);
			lim(8'h35, 16'hE908, 1, 16'hE908);
			lim(8'h35, 16'hE921, 0, 16'hE908);
			lim(8'h35, 16'hE118, 0, 16'hE908);
			lim(8'h46, 16'hE370, 1, 16'hE370);
			lim(8'h46, 16'hE7F0, 0, 16'hE370);
			lim(8'h4A, 16'hE210, 1, 16'hE210);
			lim(8'h51, 16'hF064, 1, 16'hF064);
			lim(8'h51, 16'hF21D, 0, 16'hF064);
			lim(8'h4F, 16'hF21C, 1, 16'hF21C);
			lim(8'h55, 16'hE980, 1, 16'hE980);
			lim(8'h55, 16'hEB21, 0, 16'hE980);
			lim(8'h60, 16'hF827, 0, 16'hF828);
			lim(8'h60, 16'hFBE8, 1, 16'hFBE8);
			lim(8'h61, 16'hF81D, 0, 16'hF83C);
			lim(8'h61, 16'hF81E, 1, 16'hF81E);
			lim(8'h42, 16'hB000, 1, 16'hB000);
			lim(8'h40, 16'hFE67, 0, 16'hF000);
			lim(8'h5E, 16'hD333, 1, 16'hD333);
			lim(8'h5F, 16'h7FFF, 0, 16'h9000);
		end
	endtask
	task t_conditions;
		reg [15:0] r;
		begin
			gap = 2;
			@(posedge core_clk);
			vout_meas <= 16'hFFFF;
			iout_meas <= 11'h3FF;
			temp_meas <= 11'h230;
			repeat (4) @(posedge core_clk);
			rdm(8'h7A, 16'h00C0, 16'h00C0);
			rdm(8'h7B, 16'h00A0, 16'h00A0);
			rdm(8'h79, 16'hC834, 16'hC834);
			acc(1, 8'h7A, 16'h0080, 0, 1, r);
			rdm(8'h7A, 16'h0080, 16'h0080);
			@(posedge core_clk);
			vout_meas <= 16'h0000;
			iout_meas <= 11'h000;
			repeat (4) @(posedge core_clk);
			rdm(8'h7A, 16'h00C0, 16'h00C0);
			acc(1, 8'h7A, 16'h0080, 0, 1, r);
			rdm(8'h7A, 16'h00C0, 16'h0040);
			acc(1, 8'h7A, 16'h0040, 0, 1, r);
			acc(1, 8'h7B, 16'h00A0, 0, 1, r);
			rdm(8'h7B, 16'h00A0, 16'h0000);
			rdm(8'h79, 16'hC030, 16'h0000);
			gap = 0;
		end
	endtask
	task t_start;
		reg [15:0] r;
		begin
			@(posedge core_clk);
			reset_n <= 1'b0;
			@(posedge core_clk);
			reset_n <= 1'b1;
			lim(8'h35, 16'hE918, 1, 16'hE918);
			rdm(8'h79, 16'h0040, 16'h0040);
			// turn-on waits are millions of cycles, so only the early part is seen
			@(posedge core_clk);
			start_req <= 1'b1;
			for (int i = 0; i < 300; i++) begin
				@(posedge core_clk);
				chk("ramp", 16'h0000, {4'h0, ramp_target_frac, ramp_active, pgood});
			end
			rdm(8'h79, 16'h0840, 16'h0800);
		end
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		tick_in = 1'b0;
		#7;
		forever #40 tick_in = ~tick_in;
	end
	initial begin
		errors = 0;
		comparisons = 0;
		gap = 0;
		reset_n = 1'b0;
		vout_meas = 16'h0000;
		iout_meas = 11'h000;
		temp_meas = 11'h064;
		vin_meas = 11'h130;
		start_req = 1'b0;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		t_defaults;
		t_limits;
		t_conditions;
		t_start;
		final_report;
	end
endmodule // plsc_bank_tb
bind plsc_bank plsc_bank_properties plsc_bank_properties_i (.core_clk(core_clk), .reset_n(reset_n),
	.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_word(cmd_word),
	.cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_rej(cmd_rej), .pgood(pgood));

// ### plsc_consts.vh
// constants for the limit and status command bank
`ifndef PLSC_CONSTS_VH
`define PLSC_CONSTS_VH
`define PLSC_CMD_VIN_ON 8'h35
`define PLSC_CMD_VIN_OFF 8'h36
`define PLSC_CMD_VOUT_OVF 8'h40
`define PLSC_CMD_VOUT_OVF_ACT 8'h41
`define PLSC_CMD_VOUT_OVW 8'h42
`define PLSC_CMD_IOUT_OCF 8'h46
`define PLSC_CMD_IOUT_OCF_ACT 8'h47
`define PLSC_CMD_IOUT_OCW 8'h4A
`define PLSC_CMD_OTF 8'h4F
`define PLSC_CMD_OTF_ACT 8'h50
`define PLSC_CMD_OTW 8'h51
`define PLSC_CMD_VIN_OVF 8'h55
`define PLSC_CMD_VIN_OVF_ACT 8'h56
`define PLSC_CMD_PG_ON 8'h5E
`define PLSC_CMD_PG_OFF 8'h5F
`define PLSC_CMD_TON_WAIT 8'h60
`define PLSC_CMD_TON_RAMP 8'h61
`define PLSC_CMD_SUMMARY 8'h79
`define PLSC_CMD_VOUT_COND 8'h7A
`define PLSC_CMD_IOUT_COND 8'h7B
// linear11 exponents, 5-bit two's complement
`define PLSC_EXP_M3 5'h1D
`define PLSC_EXP_M4 5'h1C
`define PLSC_EXP_M2 5'h1E
`define PLSC_EXP_M1 5'h1F
// reset values, linear words (vout words are 16-bit mantissa, exp -12)
`define PLSC_RST_VIN_ON 16'hE918
`define PLSC_RST_VIN_OFF 16'hE908
`define PLSC_RST_VOUT_OVF 16'hF000
`define PLSC_RST_VOUT_OVW 16'hE000
`define PLSC_RST_IOUT_OCF 16'hE350
`define PLSC_RST_IOUT_OCW 16'hE2F0
`define PLSC_RST_OTF 16'hF1F4
`define PLSC_RST_OTW 16'hF190
`define PLSC_RST_VIN_OVF 16'hEB20
`define PLSC_RST_PG_ON 16'hB000
`define PLSC_RST_PG_OFF 16'h9000
`define PLSC_RST_TON_WAIT 16'hF828
`define PLSC_RST_TON_RAMP 16'hF83C
`define PLSC_RST_OVF_ACT 8'hB8
`define PLSC_RST_OCF_ACT 8'hF8
`define PLSC_RST_OTF_ACT 8'hB8
`define PLSC_RST_VINF_ACT 8'hF8
// mantissa ranges
`define PLSC_MIN_VIN_ON 11'h108
`define PLSC_MAX_VIN_ON 11'h120
`define PLSC_MIN_VIN_OFF 11'h0F8
`define PLSC_MAX_VIN_OFF 11'h110
`define PLSC_MIN_IOUT 11'h210
`define PLSC_MAX_IOUT 11'h370
`define PLSC_MIN_TEMP 11'h064
`define PLSC_MAX_TEMP 11'h21C
`define PLSC_MIN_VIN_OVF 11'h180
`define PLSC_MAX_VIN_OVF 11'h320
`define PLSC_MIN_TON_WAIT 11'h028
`define PLSC_MAX_TON_WAIT 11'h3E8
`define PLSC_MIN_TON_RAMP 11'h01E
`define PLSC_MAX_TON_RAMP 11'h3E8
`define PLSC_MIN_VOUT_OV 16'hB000
`define PLSC_MAX_VOUT_OV 16'hFE66
`define PLSC_MIN_VOUT_PG 16'h8000
`define PLSC_MAX_VOUT_PG 16'hD333
// condition bit positions
`define PLSC_VC_OVF 7
`define PLSC_VC_OVW 6
`define PLSC_IC_OCF 7
`define PLSC_IC_OCW 5
`define PLSC_SW_VOUT 15
`define PLSC_SW_IOUT 14
`define PLSC_SW_INPUT 13
`define PLSC_SW_PGN 11
`define PLSC_SW_OFF 6
`define PLSC_SW_VOV 5
`define PLSC_SW_IOC 4
`define PLSC_SW_VUV 3
`define PLSC_SW_TEMP 2
// timing: 0.5 ms at 100 MHz in core_clk cycles; ms period per lsb of time words is 0.5 ms
`define PLSC_CLK_MHZ 100
`define PLSC_HALF_MS_US 500
`define PLSC_HALF_MS_CYC 16'hC350
`endif

// ### plsc_host.sv
// host controller model issuing one command at a time
`timescale 1ns/10ps
module plsc_host (
	input wire core_clk,
	output reg cmd_wr,
	output reg cmd_rd,
	output reg [7:0] cmd_code,
	output reg [15:0] cmd_wdata,
	output reg cmd_word,
	input wire [15:0] cmd_rdata,
	input wire cmd_ack,
	input wire cmd_rej
);
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
		cmd_word = 1'b0;
	end
	// gap idles first, so the host can be slow as well as prompt
	task xfer(input bit wr, input [7:0] code, input [15:0] d, input bit word, input int gap,
		output bit ack, output bit rej, output [15:0] rd, output bit hung);
		int n;
		begin
			hung = 1'b1;
			repeat (gap) @(posedge core_clk);
			@(posedge core_clk);
			cmd_wr <= wr;
			cmd_rd <= !wr;
			cmd_code <= code;
			cmd_wdata <= d;
			cmd_word <= word;
			@(posedge core_clk);
			cmd_wr <= 1'b0;
			cmd_rd <= 1'b0;
			// code and data lines change so a stale value never looks valid
			cmd_code <= ~code;
			cmd_wdata <= ~d;
			for (n = 0; n < 4 && hung; n++) begin
				#1;
				ack = cmd_ack;
				rej = cmd_rej;
				rd = cmd_rdata;
				if (ack || rej) hung = 1'b0;
				else @(posedge core_clk);
			end
		end
	endtask
endmodule // plsc_host

// ### plsc_ltck.v
// range check of a linear word against a fixed exponent and mantissa window
`timescale 1ns/10ps
module plsc_ltck #(
	parameter [4:0] EXP = 5'h00,
	parameter [10:0] MIN = 11'h000,
	parameter [10:0] MAX = 11'h7FF
) (
	input wire [15:0] word,
	output wire ok
);
	// only the fixed exponent is accepted; mantissa compared unsigned as ranges are positive
	assign ok = (word[15:11] == EXP) && !word[10] && (word[10:0] >= MIN) && (word[10:0] <= MAX);
endmodule // plsc_ltck

// ### plsc_sync.v
// two-flop synchroniser for one level
`timescale 1ns/10ps
module plsc_sync (
	input wire core_clk,
	input wire reset_n,
	input wire din,
	output reg dout
);
	reg meta_r;
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule // plsc_sync
